// ==== include/radio_pkt_pkg.sv ====
package radio_pkt_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] addr_config_main = 12'h4c0;
  localparam logic [11:0] addr_wait_times  = 12'h4c8;
  localparam logic [11:0] addr_status      = 12'h4d0;
  localparam logic [31:0] config_reset     = 32'h0000_0000;
  localparam logic [31:0] wait_reset       = 32'h0000_0000;
  // ****************************************
  // main configuration fields
  // ****************************************
  localparam int tx_len_lsb     = 24;
  localparam int rx_len_lsb     = 16;
  localparam int len_bits       = 8;
  localparam int addr_excl_bit  = 15;
  localparam int crc24_bit      = 14;
  localparam int addr_width_lsb = 12;
  localparam int dyn_pay_bit    = 11;
  localparam int crc_en_bit     = 10;
  localparam int crc16_bit      = 9;
  localparam int scramble_bit   = 8;
  localparam int enhanced_bit   = 6;
  localparam int rate_bit       = 5;
  localparam int mode_lsb       = 3;
  localparam int no_reply_bit   = 1;
  localparam int role_bit       = 0;
  // ****************************************
  // wait-time fields
  // ****************************************
  localparam int wait_bits      = 15;
  localparam int turn_wait_lsb  = 0;
  localparam int rx_wait_lsb    = 16;
  // ****************************************
  // status fields
  // ****************************************
  localparam int st_tx_pid_lsb  = 0;
  localparam int st_rx_pid_lsb  = 2;
  localparam int st_timeout_bit = 4;
  localparam int st_failed_bit  = 5;
  localparam int st_state_lsb   = 8;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] mode_ble     = 2'h1;
  localparam logic [1:0] mode_fam_a   = 2'h2;
  localparam logic [1:0] mode_fam_b   = 2'h3;
  localparam logic [1:0] aw_invalid   = 2'h0;
  localparam logic [1:0] pid_step     = 2'h1;
  localparam logic [2:0] addr_base    = 3'h2;
  localparam logic [1:0] crc_none     = 2'h0;
  localparam logic [1:0] crc_one      = 2'h1;
  localparam logic [1:0] crc_two      = 2'h2;
  localparam logic [1:0] crc_three    = 2'h3;
  localparam int         timer_bits   = 18;

  typedef enum logic [4:0] {
    st_idle   = 5'b00001,
    st_send   = 5'b00010,
    st_gap_rx = 5'b00100,
    st_listen = 5'b01000,
    st_gap_tx = 5'b10000
  } link_state_type;

  // address width field to byte count, 0 when invalid
  function automatic logic [2:0] addr_bytes_of(input logic [1:0] field);
    addr_bytes_of = (field == aw_invalid) ? 3'h0 : (addr_base + {1'b0, field});
  endfunction : addr_bytes_of
endpackage : radio_pkt_pkg

// ==== hw/span_counter.sv ====
`timescale 1ns/1ns
// ****************************************
// loadable down-counter with expiry pulse
// ****************************************
module span_counter #(
  parameter int WIDTH = 18
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             halt,
  // status
  output logic                  running,
  output logic                  expired
);
  initial begin
    if (WIDTH < 2) $error("span_counter width too small");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             run_q;
  logic             run_d;
  logic             exp_q;
  logic             exp_d;

  always_comb begin
    count_d = count_q;
    run_d   = run_q;
    exp_d   = 1'b0;
    if (load) begin
      count_d = load_value;
      run_d   = 1'b1;
    end else if (halt) begin
      run_d = 1'b0;
    end else if (run_q) begin
      // a zero load expires on the next edge, never wraps
      if (count_q <= WIDTH'(1)) begin
        count_d = '0;
        run_d   = 1'b0;
        exp_d   = 1'b1;
      end else begin
        count_d = count_q - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      run_q   <= 1'b0;
      exp_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      run_q   <= run_d;
      exp_q   <= exp_d;
    end
  end

  assign running = run_q;
  assign expired = exp_q;
endmodule : span_counter

// ==== hw/radio_pkt_ctrl.sv ====
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
// Contract
// RL1 - tx-to-rx gap is wait, both latencies, send tail, listen lead; rx-to-tx similar; gap_to_send here leaves out both latencies
// RL2 - the wait part of each turnaround comes from the programmed field
// RL3 - software keeps the amplifier-off delay above the transmit latency
// RL4 - software computes lead and tail times and stores them in sequence memory
// RL5 - amplifier start time is sequence latency plus serial configuration time
// RL6 - listen timeout counter loads from receive wait, stops on sync word
// RL7 - two-bit packet id lets receiver drop retransmitted duplicates
// RL8 - transmitter bumps its id after a timely acknowledgement, else keeps it
// RL9 - software may supply the packet id itself; not offered here, tx_pid only comes from the internal counter
// RL10 - exclusion bit drops access address from checksum and scrambling coverage
// RL11 - checksum on when bit 10 set; bit 14 picks 24, else bit 9
// RL12 - address width 01/10/11 gives 3/4/5 bytes, 00 invalid, low bytes
// RL13 - dynamic payload in enhanced mode takes length from packet
// RL14 - enhanced transmitter expecting payload acks sets dynamic payload
// RL15 - scrambling only while bit 8 is set
// RL16 - mode field picks ble or one of two families; ble gates clock
// RL17 - no-reply request sets flag; receiver then sends no acknowledgement
// RL18 - bit 0 picks receiver or transmitter role; bit 5 picks 2 Mbps
// RL19 - payload byte counts at bits 31:24 and 23:16
// RL20 - turnaround wait is 15 bits at 14:0 of wait register
// RL21 - receive wait at 30:16; expiry fails the transmission for resend
module radio_pkt_ctrl
  import radio_pkt_pkg::*;
#(
  parameter int TX_LATENCY      = 4,
  parameter int RX_LATENCY      = 4,
  parameter int SERIAL_BYTE_CYC = 8
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sequence memory timing values
  input  wire logic [15:0] lead_before_send,
  input  wire logic [15:0] tail_after_send,
  input  wire logic [15:0] lead_before_listen,
  input  wire logic [15:0] tail_after_listen,
  input  wire logic [15:0] seq_on_latency,
  input  wire logic [7:0]  serial_cfg_bytes,
  // link events
  input  wire logic        start_pulse,
  input  wire logic        frame_sent,
  input  wire logic        sync_word_detected,
  input  wire logic        frame_received,
  input  wire logic [1:0]  rx_pid_field,
  input  wire logic        rx_no_reply_flag,
  input  wire logic [7:0]  rx_length_field,
  // link control
  output logic             switch_to_listen,
  output logic             switch_to_send,
  output logic             send_reply,
  output logic             store_packet,
  output logic             listen_timeout,
  output logic             send_failed,
  output logic [1:0]       tx_pid,
  output logic             tx_no_reply_flag,
  output logic [17:0]      amp_start_span,
  // packet format
  output logic             pkt_clk_en,
  output logic             role_receiver,
  output logic             rate_2m,
  output logic [1:0]       frame_family,
  output logic             enhanced_mode,
  output logic [2:0]       addr_bytes,
  output logic             crc_on,
  output logic [1:0]       crc_bytes,
  output logic             crc_covers_addr,
  output logic             scramble_on,
  output logic             scramble_covers_addr,
  output logic [7:0]       tx_payload_len,
  output logic [7:0]       rx_payload_len
);
  initial begin
    if (TX_LATENCY < 0 || TX_LATENCY > 32767) $error("TX_LATENCY out of range");
    if (RX_LATENCY < 0 || RX_LATENCY > 32767) $error("RX_LATENCY out of range");
    if (SERIAL_BYTE_CYC < 1 || SERIAL_BYTE_CYC > 255) $error("SERIAL_BYTE_CYC out of range");
  end

  // ****************************************
  // register bank
  // ****************************************
  logic [31:0] config_q, config_d, wait_q, wait_d, rdata_q, rdata_d, status_word;
  logic        wr_access, setup, mapped;

  link_state_type state_q, state_d;
  logic [1:0]     tx_pid_q, tx_pid_d, rx_pid_q, rx_pid_d;
  logic           rx_seen_q, rx_seen_d, timeout_q, timeout_d, failed_q, failed_d;

  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign mapped    = (paddr == addr_config_main) | (paddr == addr_wait_times) | (paddr == addr_status);

  always_comb begin
    status_word                     = '0;
    status_word[st_tx_pid_lsb +: 2] = tx_pid_q;
    status_word[st_rx_pid_lsb +: 2] = rx_pid_q;
    status_word[st_timeout_bit]     = timeout_q;
    status_word[st_failed_bit]      = failed_q;
    status_word[st_state_lsb +: 5]  = state_q;
  end

  always_comb begin
    config_d = config_q;
    wait_d   = wait_q;
    rdata_d  = rdata_q;
    if (wr_access && paddr == addr_config_main) begin
      config_d = pwdata;
    end
    if (wr_access && paddr == addr_wait_times) begin
      // bits 31 and 15 are not kept here and read as zero
      wait_d = '0;
      wait_d[turn_wait_lsb +: wait_bits] = pwdata[turn_wait_lsb +: wait_bits]; // see RL20
      wait_d[rx_wait_lsb +: wait_bits]   = pwdata[rx_wait_lsb +: wait_bits];   // see RL21
    end
    // read data is captured in the setup phase so prdata leaves a flop
    if (setup) begin
      case (paddr)
        addr_config_main: rdata_d = config_q;
        addr_wait_times:  rdata_d = wait_q;
        addr_status:      rdata_d = status_word;
        default:          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= config_reset;
      wait_q   <= wait_reset;
      rdata_q  <= '0;
    end else begin
      config_q <= config_d;
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************
  // configuration decode
  // ****************************************
  logic       excl_addr, dyn_pay, no_reply_req;
  logic [1:0] mode_field;

  assign excl_addr      = config_q[addr_excl_bit];
  assign mode_field     = config_q[mode_lsb +: 2];
  assign dyn_pay        = config_q[dyn_pay_bit];
  assign no_reply_req   = config_q[no_reply_bit];
  assign enhanced_mode  = config_q[enhanced_bit];
  assign pkt_clk_en     = (mode_field != mode_ble);                  // see RL16
  assign frame_family   = mode_field;                                // see RL16
  assign role_receiver  = config_q[role_bit];                        // see RL18
  assign rate_2m        = config_q[rate_bit];                        // see RL18
  assign addr_bytes     = addr_bytes_of(config_q[addr_width_lsb +: 2]); // see RL12
  assign crc_on         = config_q[crc_en_bit];                      // see RL11
  assign crc_covers_addr      = ~excl_addr;                          // see RL10
  assign scramble_covers_addr = ~excl_addr;                          // see RL10
  assign scramble_on    = config_q[scramble_bit];                    // see RL15
  assign tx_payload_len = config_q[tx_len_lsb +: len_bits];          // see RL19

  always_comb begin
    if (!crc_on) begin
      crc_bytes = crc_none;
    end else if (config_q[crc24_bit]) begin // see RL11
      crc_bytes = crc_three;
    end else if (config_q[crc16_bit]) begin
      crc_bytes = crc_two;
    end else begin
      crc_bytes = crc_one;
    end
  end

  // dynamic payload only counts in enhanced mode
  assign rx_payload_len = (enhanced_mode && dyn_pay) ? rx_length_field
                                                     : config_q[rx_len_lsb +: len_bits]; // see RL13 RL19
  assign tx_no_reply_flag = enhanced_mode & no_reply_req; // see RL17
  assign tx_pid           = tx_pid_q;

  // ****************************************
  // turnaround and listen timers
  // ****************************************
  localparam logic [timer_bits-1:0] tx_lat = timer_bits'(TX_LATENCY);
  localparam logic [timer_bits-1:0] rx_lat = timer_bits'(RX_LATENCY);
  localparam logic [timer_bits-1:0] byte_cyc = timer_bits'(SERIAL_BYTE_CYC);

  logic [timer_bits-1:0] turn_wait, gap_to_listen, gap_to_send, gap_value, listen_span, amp_span_d, amp_span_q;
  logic                  gap_load, gap_expired, listen_load, listen_halt, listen_expired;

  assign turn_wait   = timer_bits'(wait_q[turn_wait_lsb +: wait_bits]); // see RL2
  assign listen_span = timer_bits'(wait_q[rx_wait_lsb +: wait_bits]);   // see RL6
  // sums fit: three 15-bit terms and two 16-bit terms stay under 18 bits
  assign gap_to_listen = turn_wait + tx_lat + rx_lat
                       + timer_bits'(tail_after_send) + timer_bits'(lead_before_listen); // see RL1
  assign gap_to_send   = turn_wait + timer_bits'(tail_after_listen)
                       + timer_bits'(lead_before_send); // see RL1
  assign amp_span_d    = timer_bits'(seq_on_latency)
                       + timer_bits'(serial_cfg_bytes) * byte_cyc; // see RL5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_span_q <= '0;
    end else begin
      amp_span_q <= amp_span_d;
    end
  end

  assign amp_start_span = amp_span_q;

  span_counter #(
    .WIDTH(timer_bits)
  ) u_gap_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (gap_load),
    .load_value (gap_value),
    .halt       (1'b0),
    .running    (),
    .expired    (gap_expired)
  );

  span_counter #(
    .WIDTH(timer_bits)
  ) u_listen_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (listen_load),
    .load_value (listen_span),
    .halt       (listen_halt),
    .running    (),
    .expired    (listen_expired)
  );

  // ****************************************
  // link sequencer
  // ****************************************
  logic sw_listen_d, sw_send_d, reply_d, store_d, to_d, fail_d;
  logic sw_listen_q, sw_send_q, reply_q, store_q, to_q, fail_q;
  logic duplicate;

  assign duplicate = rx_seen_q && (rx_pid_field == rx_pid_q); // see RL7

  always_comb begin
    state_d     = state_q;
    tx_pid_d    = tx_pid_q;
    rx_pid_d    = rx_pid_q;
    rx_seen_d   = rx_seen_q;
    timeout_d   = timeout_q;
    failed_d    = failed_q;
    gap_load    = 1'b0;
    gap_value   = gap_to_listen;
    listen_load = 1'b0;
    listen_halt = sync_word_detected; // see RL6
    sw_listen_d = 1'b0;
    sw_send_d   = 1'b0;
    reply_d     = 1'b0;
    store_d     = 1'b0;
    to_d        = 1'b0;
    fail_d      = 1'b0;
    case (state_q)
      st_idle: begin
        if (start_pulse && pkt_clk_en) begin
          timeout_d = 1'b0;
          failed_d  = 1'b0;
          if (role_receiver) begin
            listen_load = 1'b1;
            state_d     = st_listen;
          end else begin
            state_d = st_send;
          end
        end
      end
      st_send: begin
        if (frame_sent) begin
          if (role_receiver || tx_no_reply_flag) begin
            // no reply expected, the packet counts as delivered
            if (!role_receiver) begin
              tx_pid_d = tx_pid_q + pid_step;
            end
            state_d = st_idle;
          end else begin
            gap_load = 1'b1;
            state_d  = st_gap_rx;
          end
        end
      end
      st_gap_rx: begin
        if (gap_expired) begin
          sw_listen_d = 1'b1;
          listen_load = 1'b1;
          state_d     = st_listen;
        end
      end
      st_listen: begin
        if (frame_received) begin
          listen_halt = 1'b1;
          if (role_receiver) begin
            store_d   = ~duplicate;    // see RL7
            rx_pid_d  = rx_pid_field;
            rx_seen_d = 1'b1;
            if (enhanced_mode && !rx_no_reply_flag) begin // see RL17
              gap_value = gap_to_send;
              gap_load  = 1'b1;
              state_d   = st_gap_tx;
            end else begin
              state_d = st_idle;
            end
          end else begin
            tx_pid_d = tx_pid_q + pid_step; // see RL8
            rx_pid_d = rx_pid_field;
            state_d  = st_idle;
          end
        end else if (listen_expired) begin
          to_d      = 1'b1;
          timeout_d = 1'b1;
          if (!role_receiver) begin
            // id held so the resend carries the same value
            fail_d   = 1'b1;            // see RL21
            failed_d = 1'b1;
          end
          state_d = st_idle;
        end
      end
      st_gap_tx: begin
        if (gap_expired) begin
          sw_send_d = 1'b1;
          reply_d   = 1'b1;
          state_d   = st_send;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
    // gated clock in ble mode: sequencer parks
    if (!pkt_clk_en) begin // see RL16
      state_d = st_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= st_idle;
      tx_pid_q    <= '0;
      rx_pid_q    <= '0;
      rx_seen_q   <= 1'b0;
      timeout_q   <= 1'b0;
      failed_q    <= 1'b0;
      sw_listen_q <= 1'b0;
      sw_send_q   <= 1'b0;
      reply_q     <= 1'b0;
      store_q     <= 1'b0;
      to_q        <= 1'b0;
      fail_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      tx_pid_q    <= tx_pid_d;
      rx_pid_q    <= rx_pid_d;
      rx_seen_q   <= rx_seen_d;
      timeout_q   <= timeout_d;
      failed_q    <= failed_d;
      sw_listen_q <= sw_listen_d;
      sw_send_q   <= sw_send_d;
      reply_q     <= reply_d;
      store_q     <= store_d;
      to_q        <= to_d;
      fail_q      <= fail_d;
    end
  end

  assign switch_to_listen = sw_listen_q;
  assign switch_to_send   = sw_send_q;
  assign send_reply       = reply_q;
  assign store_packet     = store_q;
  assign listen_timeout   = to_q;
  assign send_failed      = fail_q;
endmodule : radio_pkt_ctrl

// ==== sim/radio_pkt_ctrl_props.sv ====
`timescale 1ns/1ns
// ****
// port checks
// ****
module radio_pkt_ctrl_props
  import radio_pkt_pkg::*;
#(
  parameter int SERIAL_BYTE_CYC = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // timing inputs
  input wire logic [15:0] seq_on_latency,
  input wire logic [7:0]  serial_cfg_bytes,
  // link control
  input wire logic        switch_to_listen,
  input wire logic        switch_to_send,
  input wire logic        send_reply,
  input wire logic        listen_timeout,
  input wire logic        send_failed,
  input wire logic [1:0]  tx_pid,
  input wire logic        tx_no_reply_flag,
  input wire logic [17:0] amp_start_span,
  // packet format
  input wire logic        pkt_clk_en,
  input wire logic        role_receiver,
  input wire logic [1:0]  frame_family,
  input wire logic        enhanced_mode,
  input wire logic [2:0]  addr_bytes,
  input wire logic        crc_covers_addr,
  input wire logic        scramble_covers_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_ready; s_setup ##1 s_access |-> pready; endproperty
  property p_gate; pkt_clk_en == (frame_family != mode_ble); endproperty
  property p_width; addr_bytes inside {3'h0, 3'h3, 3'h4, 3'h5}; endproperty
  property p_cover; crc_covers_addr == scramble_covers_addr; endproperty
  property p_noreply; tx_no_reply_flag |-> enhanced_mode; endproperty
  property p_fail; listen_timeout && !role_receiver |-> send_failed; endproperty
  property p_pid; tx_pid != $past(tx_pid) |-> tx_pid == $past(tx_pid) + pid_step; endproperty
  property p_amp;
    presetn |=> amp_start_span == 18'($past(seq_on_latency)) + 18'($past(serial_cfg_bytes)) * SERIAL_BYTE_CYC;
  endproperty
  property p_reply; send_reply |-> switch_to_send; endproperty
  property p_pulse; switch_to_listen |=> !switch_to_listen; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  a_gate: assert property (p_gate) else $error("clock gate wrong");
  a_width: assert property (p_width) else $error("address bytes bad");
  a_cover: assert property (p_cover) else $error("coverage differs");
  a_noreply: assert property (p_noreply) else $error("flag outside enhanced");
  a_fail: assert property (p_fail) else $error("timeout without fail");
  a_pid: assert property (p_pid) else $error("pid jumped");
  a_amp: assert property (p_amp) else $error("amp span wrong");
  a_reply: assert property (p_reply) else $error("reply without switch");
  a_pulse: assert property (p_pulse) else $error("switch too long");
endmodule : radio_pkt_ctrl_props

bind radio_pkt_ctrl radio_pkt_ctrl_props #(.SERIAL_BYTE_CYC(SERIAL_BYTE_CYC)) i_radio_pkt_ctrl_props (.*);

// ==== sim/radio_pkt_peer.sv ====
`timescale 1ns/1ns
// ****
// peer radio across the air
// ****
module radio_pkt_peer (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // block and bench
  input wire logic       start_pulse,
  input wire logic       switch_to_listen,
  input wire logic       switch_to_send,
  input wire logic       role_receiver,
  input wire logic       reply_on,
  input wire logic [1:0] pid,
  input wire logic       no_reply,
  // air events
  output logic           frame_sent,
  output logic           sync_word_detected,
  output logic           frame_received,
  output logic [1:0]     rx_pid_field,
  output logic           rx_no_reply_flag,
  output logic [7:0]     rx_length_field
);
  int send_cnt;
  int rcv_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {frame_sent, sync_word_detected, frame_received} <= 3'h0;
      {rx_pid_field, rx_no_reply_flag, rx_length_field} <= 11'h0;
      send_cnt <= 0;
      rcv_cnt <= 0;
    end else begin
      {frame_sent, sync_word_detected, frame_received} <= 3'h0;
      // flip outside frames so stale fields never hold steady
      {rx_pid_field, rx_no_reply_flag, rx_length_field} <= ~{rx_pid_field, rx_no_reply_flag, rx_length_field};
      send_cnt <= (send_cnt > 0) ? send_cnt - 1 : 0;
      rcv_cnt <= (rcv_cnt > 0) ? rcv_cnt - 1 : 0;
      if ((start_pulse && !role_receiver) || switch_to_send) send_cnt <= 5;
      if (((start_pulse && role_receiver) || switch_to_listen) && reply_on) rcv_cnt <= 6;
      if (send_cnt == 1) frame_sent <= 1'b1;
      if (rcv_cnt == 2) sync_word_detected <= 1'b1;
      if (rcv_cnt == 1) begin
        frame_received <= 1'b1;
        {rx_pid_field, rx_no_reply_flag, rx_length_field} <= {pid, no_reply, 8'h2a + 8'(pid)};
      end
    end
  end
endmodule : radio_pkt_peer

// ==== sim/tb_radio_pkt_ctrl.sv ====
`timescale 1ns/1ns
// ****
// bench
// ****
module tb_radio_pkt_ctrl;
  import radio_pkt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, c, w;
  logic [15:0] lead_before_send, tail_after_send, lead_before_listen, tail_after_listen, seq_on_latency;
  logic [7:0]  serial_cfg_bytes, rx_length_field, tx_payload_len, rx_payload_len;
  logic        start_pulse, frame_sent, sync_word_detected, frame_received, rx_no_reply_flag;
  logic [1:0]  rx_pid_field, tx_pid, crc_bytes, frame_family, pid;
  logic        switch_to_listen, switch_to_send, send_reply, store_packet, listen_timeout, send_failed;
  logic        tx_no_reply_flag, pkt_clk_en, role_receiver, rate_2m, enhanced_mode, crc_on;
  logic        crc_covers_addr, scramble_on, scramble_covers_addr, reply_on, no_reply;
  logic [17:0] amp_start_span;
  logic [2:0]  addr_bytes;
  logic [32:0] rq[$], eq[$];
  int          fail_count, comparisons, cyc, t_sent, st_cnt, rp_cnt, tw, k;

  radio_pkt_ctrl i_radio_pkt_ctrl (.*);
  radio_pkt_peer i_radio_pkt_peer (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // reads queue {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic exchange(input logic [31:0] cfg, input logic on, input logic [1:0] p, input logic nr);
    tw = $urandom_range(9, 2);
    apb(1'b1, addr_config_main, cfg, '0);
    apb(1'b1, addr_wait_times, {1'b0, 15'd40, 1'b0, 15'(tw)}, '0);
    if (!cfg[role_bit] && !(cfg[enhanced_bit] && cfg[no_reply_bit])) eq.push_back(33'(tw + 19));
    {reply_on, pid, no_reply} <= {on, p, nr};
    start_pulse <= 1'b1;
    @(posedge pclk);
    start_pulse <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge pclk);
      if (frame_received || listen_timeout) break;
    end
    @(posedge pclk);
    reply_on <= 1'b0;
    // reply and timeout room
    repeat (80) @(posedge pclk);
  endtask : exchange

  always @(posedge pclk) begin
    cyc++;
    if (presetn) begin
      if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rq.pop_front());
      if (frame_sent) t_sent = cyc;
      if (switch_to_listen && !role_receiver) check(33'(cyc - t_sent), eq.pop_front());
      if (frame_received && enhanced_mode) check(33'(rx_payload_len), 33'(rx_length_field));
      st_cnt += int'(store_packet);
      rp_cnt += int'(send_reply);
    end
  end

  initial begin
    void'($urandom(32'h1c795c8c));
    {psel, penable, pwrite, start_pulse, reply_on, no_reply, pid} = '0;
    paddr = '0;
    pwdata = '0;
    lead_before_send = 16'h0002;
    tail_after_send = 16'h0006;
    lead_before_listen = 16'h0003;
    tail_after_listen = 16'h0001;
    seq_on_latency = 16'($urandom);
    serial_cfg_bytes = 8'($urandom);
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, addr_config_main, '0, {1'b0, config_reset});
    apb(1'b0, addr_wait_times, '0, {1'b0, wait_reset});
    w = $urandom;
    apb(1'b1, addr_wait_times, w, '0);
    apb(1'b0, addr_wait_times, '0, {1'b0, w & 32'h7fff_7fff});
    apb(1'b0, 12'h4fc, '0, {1'b1, 32'h0});
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      c = ($urandom & 32'hffff_cfa7) | 32'h0000_0400 | (k << 12) | (k << 3);
      apb(1'b1, addr_config_main, c, '0);
      apb(1'b0, addr_config_main, '0, {1'b0, c});
      check({1'b0, pkt_clk_en, addr_bytes, crc_bytes, crc_covers_addr, scramble_covers_addr, scramble_on, crc_on,
             rate_2m, role_receiver, frame_family, enhanced_mode, tx_no_reply_flag, tx_payload_len, rx_payload_len},
            {1'b0, k != 1, (k == 0) ? 3'h0 : 3'(k + 2), c[14] ? 2'h3 : (c[9] ? 2'h2 : 2'h1), ~c[15], ~c[15], c[8],
             1'b1, c[5], c[0], 2'(k), 2'h0, c[31:16]});
    end
    $display("test format done");
    exchange(32'h1020_1d50, 1'b1, 2'h0, 1'b0);
    check(33'(tx_pid), 33'h1);
    exchange(32'h1020_1d50, 1'b0, 2'h0, 1'b0);
    check(33'(tx_pid), 33'h1);
    exchange(32'h1020_1d52, 1'b0, 2'h0, 1'b0);
    check(33'(tx_no_reply_flag), 33'h1);
    check(33'(tx_pid), 33'h2);
    $display("test transmitter done");
    exchange(32'h1020_1d51, 1'b1, 2'h2, 1'b0);
    exchange(32'h1020_1d51, 1'b1, 2'h2, 1'b1);
    exchange(32'h1020_1d51, 1'b1, 2'h3, 1'b1);
    check(33'(st_cnt), 33'h2);
    check(33'(rp_cnt), 33'h1);
    $display("test receiver done");
    check(33'(eq.size() + rq.size()), '0);
    end_of_test();
  end

  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
endmodule : tb_radio_pkt_ctrl
